// *** hdl/ssdec_pkg.sv ***
package ssdec_pkg;

  // ==========================================================================
  // Register map (byte addresses on the AXI4-Lite bus).
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_INSTR = 8'h04;
  localparam logic [7:0] ADDR_RESULT = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;

  // ==========================================================================
  // Opcode bytes.
  localparam logic [7:0] OP_ESC = 8'h0F;
  localparam logic [7:0] OP_GRP6 = 8'h00;
  localparam logic [7:0] OP_GRP7 = 8'h01;
  localparam logic [7:0] OP_DBL_LEFT_IMM = 8'hA4;
  localparam logic [7:0] OP_DBL_LEFT_CNT = 8'hA5;
  localparam logic [7:0] OP_DBL_RIGHT_IMM = 8'hAC;
  localparam logic [7:0] OP_DBL_RIGHT_CNT = 8'hAD;
  localparam logic [7:0] OP_MGMT_ENTRY = 8'h38;
  localparam logic [6:0] OP_SHIFT_ONE = 7'h68;
  localparam logic [6:0] OP_SHIFT_CNT = 7'h69;
  localparam logic [6:0] OP_SHIFT_IMM = 7'h60;
  localparam logic [6:0] OP_STRING_STORE = 7'h55;

  // ModR/M reg field selectors.
  localparam logic [2:0] REG_000 = 3'h0;
  localparam logic [2:0] REG_001 = 3'h1;
  localparam logic [2:0] REG_100 = 3'h4;
  localparam logic [2:0] REG_101 = 3'h5;

  // ==========================================================================
  // Clock counts on a cache hit.
  localparam logic [6:0] CLK_DT_STORE = 7'h06;
  localparam logic [6:0] CLK_LOCAL_STORE = 7'h01;
  localparam logic [6:0] CLK_TASK_STORE = 7'h03;
  localparam logic [6:0] CLK_MSW_STORE = 7'h04;
  localparam logic [6:0] CLK_STRING = 7'h02;
  localparam logic [6:0] CLK_ONE = 7'h01;
  localparam logic [6:0] CLK_TWO = 7'h02;
  localparam logic [6:0] CLK_DBL_IMM = 7'h03;
  localparam logic [6:0] CLK_DBL_CNT = 7'h06;
  localparam logic [6:0] CLK_MGMT = 7'h54;

  // ==========================================================================
  // Exception vectors and real-mode limit.
  localparam logic [7:0] EXC_NONE = 8'h00;
  localparam logic [7:0] EXC_INVALID = 8'h06;
  localparam logic [7:0] EXC_STACK = 8'h0C;
  localparam logic [7:0] EXC_GENERAL = 8'h0D;
  localparam logic [16:0] REAL_LIMIT = 17'h0FFFF;

  // Flag field: bits OF SF ZF AF PF CF in that order, high to low.
  localparam int FLAG_W = 6;
  localparam logic [5:0] FL_NONE = 6'h00;
  localparam logic [5:0] FL_SZPC = 6'h1B;
  localparam logic [5:0] FL_OSZPC = 6'h3B;
  localparam logic [5:0] FL_OA = 6'h24;
  localparam logic [5:0] FL_A = 6'h04;

  // Control bits, interrupt events, bus response codes and miss penalty.
  localparam int CTRL_PROT = 0;
  localparam int CTRL_GO = 1;
  localparam int CTRL_CACHE_MISS = 2;
  localparam int EV_DONE = 0;
  localparam int EV_FAULT = 1;
  localparam int EV_MGMT = 2;
  localparam int EV_W = 3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [6:0] MISS_PENALTY = 7'h04;

  // Operation classes.
  typedef enum logic [3:0] {
    ssdec_op_none,
    ssdec_op_gdt,
    ssdec_op_idt,
    ssdec_op_ldt,
    ssdec_op_task,
    ssdec_op_msw,
    ssdec_op_string,
    ssdec_op_shl,
    ssdec_op_double_left_shift,
    ssdec_op_shr,
    ssdec_op_double_right_shift,
    ssdec_op_mgmt,
    ssdec_op_invalid
  } ssdec_op_t;

  // Decode outcome for one instruction.
  typedef struct packed {
    ssdec_op_t op;
    logic [6:0] clocks;
    logic [5:0] upd_flags;
    logic [5:0] undef_flags;
    logic prot_only;
    logic mgmt_issue;
  } ssdec_dec_t;

  // Instruction presented for decode.
  typedef struct packed {
    logic [7:0] byte0;
    logic [7:0] byte1;
    logic [7:0] modrm;
    logic [7:0] seg_ss;
  } ssdec_instr_t;

endpackage : ssdec_pkg

// *** hdl/ssdec_decode.sv ***
// ==========================================================================
// Pure combinational opcode decoder.
module ssdec_decode (
  // Instruction bytes.
  input wire ssdec_pkg::ssdec_instr_t instr,
  // Decode result.
  output ssdec_pkg::ssdec_dec_t dec
);

  logic [2:0] reg_field;

  assign reg_field = instr.modrm[5:3];

  // Maps opcode and reg field to operation, count and flag effect.
  always_comb begin
    dec = '{ssdec_pkg::ssdec_op_invalid, ssdec_pkg::CLK_ONE, ssdec_pkg::FL_NONE,
             ssdec_pkg::FL_NONE, 1'b0, 1'b0};
    if (instr.byte0 == ssdec_pkg::OP_ESC) begin
      case (instr.byte1)
        ssdec_pkg::OP_GRP7: begin
          if (reg_field == ssdec_pkg::REG_000) begin
            dec.op = ssdec_pkg::ssdec_op_gdt;
            dec.clocks = ssdec_pkg::CLK_DT_STORE;
          end else if (reg_field == ssdec_pkg::REG_001) begin
            dec.op = ssdec_pkg::ssdec_op_idt;
            dec.clocks = ssdec_pkg::CLK_DT_STORE;
          end else if (reg_field == ssdec_pkg::REG_100) begin
            dec.op = ssdec_pkg::ssdec_op_msw;
            dec.clocks = ssdec_pkg::CLK_MSW_STORE;
          end
        end
        ssdec_pkg::OP_GRP6: begin
          if (reg_field == ssdec_pkg::REG_000) begin
            dec.op = ssdec_pkg::ssdec_op_ldt;
            dec.clocks = ssdec_pkg::CLK_LOCAL_STORE;
            dec.prot_only = 1'b1;
          end else if (reg_field == ssdec_pkg::REG_001) begin
            dec.op = ssdec_pkg::ssdec_op_task;
            dec.clocks = ssdec_pkg::CLK_TASK_STORE;
            dec.prot_only = 1'b1;
          end
        end
        ssdec_pkg::OP_DBL_LEFT_IMM, ssdec_pkg::OP_DBL_LEFT_CNT: begin
          dec.op = ssdec_pkg::ssdec_op_double_left_shift;
          dec.clocks = (instr.byte1 == ssdec_pkg::OP_DBL_LEFT_IMM) ?
                       ssdec_pkg::CLK_DBL_IMM : ssdec_pkg::CLK_DBL_CNT;
          dec.upd_flags = ssdec_pkg::FL_SZPC;
          dec.undef_flags = ssdec_pkg::FL_OA;
        end
        ssdec_pkg::OP_DBL_RIGHT_IMM, ssdec_pkg::OP_DBL_RIGHT_CNT: begin
          dec.op = ssdec_pkg::ssdec_op_double_right_shift;
          dec.clocks = (instr.byte1 == ssdec_pkg::OP_DBL_RIGHT_IMM) ?
                       ssdec_pkg::CLK_DBL_IMM : ssdec_pkg::CLK_DBL_CNT;
          dec.upd_flags = ssdec_pkg::FL_SZPC;
          dec.undef_flags = ssdec_pkg::FL_OA;
        end
        ssdec_pkg::OP_MGMT_ENTRY: begin
          dec.op = ssdec_pkg::ssdec_op_mgmt;
          dec.clocks = ssdec_pkg::CLK_MGMT;
          dec.mgmt_issue = 1'b1;
        end
        default: begin
          dec.op = ssdec_pkg::ssdec_op_invalid;
        end
      endcase
    end else if (instr.byte0[7:1] == ssdec_pkg::OP_STRING_STORE) begin
      dec.op = ssdec_pkg::ssdec_op_string;
      dec.clocks = ssdec_pkg::CLK_STRING;
    end else if (instr.byte0[7:1] == ssdec_pkg::OP_SHIFT_ONE ||
                 instr.byte0[7:1] == ssdec_pkg::OP_SHIFT_CNT ||
                 instr.byte0[7:1] == ssdec_pkg::OP_SHIFT_IMM) begin
      if (reg_field == ssdec_pkg::REG_100) begin
        dec.op = ssdec_pkg::ssdec_op_shl;
        dec.clocks = (instr.byte0[7:1] == ssdec_pkg::OP_SHIFT_CNT) ?
                     ssdec_pkg::CLK_TWO : ssdec_pkg::CLK_ONE;
        dec.upd_flags = (instr.byte0[7:1] == ssdec_pkg::OP_SHIFT_ONE) ?
                        ssdec_pkg::FL_OSZPC : ssdec_pkg::FL_SZPC;
        dec.undef_flags = (instr.byte0[7:1] == ssdec_pkg::OP_SHIFT_ONE) ?
                          ssdec_pkg::FL_A : ssdec_pkg::FL_OA;
      end else if (reg_field == ssdec_pkg::REG_101) begin
        dec.op = ssdec_pkg::ssdec_op_shr;
        dec.clocks = ssdec_pkg::CLK_TWO;
        dec.upd_flags = (instr.byte0[7:1] == ssdec_pkg::OP_SHIFT_ONE) ?
                        ssdec_pkg::FL_OSZPC : ssdec_pkg::FL_SZPC;
        dec.undef_flags = (instr.byte0[7:1] == ssdec_pkg::OP_SHIFT_ONE) ?
                          ssdec_pkg::FL_A : ssdec_pkg::FL_OA;
      end
    end
  end

endmodule : ssdec_decode

// *** hdl/ssdec_top.sv ***
module ssdec_top (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data.
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response.
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read.
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Interrupt.
  output logic irq
);

  // ==========================================================================
  // Execution states.
  typedef enum logic [1:0] {
    ssdec_idle,
    ssdec_run,
    ssdec_done
  } ssdec_state_t;

  // All state of the block.
  typedef struct packed {
    logic awready;
    logic wready;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [2:0] ctrl;
    ssdec_pkg::ssdec_instr_t instr;
    logic [16:0] operand_end;
    ssdec_state_t state;
    logic [6:0] count;
    ssdec_pkg::ssdec_dec_t dec;
    logic [7:0] exc;
    logic mgmt_active;
    logic [ssdec_pkg::EV_W-1:0] irq_stat;
    logic [ssdec_pkg::EV_W-1:0] irq_mask;
    logic irq;
  } ssdec_state_all_t;

  ssdec_state_all_t r;
  ssdec_state_all_t next_r;
  ssdec_pkg::ssdec_dec_t dec_now;

  // Byte-lane merge of a write into an existing word.
  function automatic logic [31:0] ssdec_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction : ssdec_merge

  // ==========================================================================
  // Decoder instance.
  ssdec_decode u_decode (
    .instr(r.instr),
    .dec(dec_now)
  );

  // ==========================================================================
  // Next-state logic.
  always_comb begin
    logic [ssdec_pkg::EV_W-1:0] ev;
    logic [31:0] wmerged;
    logic [7:0] fault;
    ev = '0;
    wmerged = '0;
    fault = ssdec_pkg::EXC_NONE;
    next_r = r;

    // Write address and data may arrive in either order.
    if (s_axi_awvalid && r.awready) begin
      next_r.aw_got = 1'b1;
      next_r.awaddr = s_axi_awaddr;
      next_r.awready = 1'b0;
    end
    if (s_axi_wvalid && r.wready) begin
      next_r.w_got = 1'b1;
      next_r.wdata = s_axi_wdata;
      next_r.wstrb = s_axi_wstrb;
      next_r.wready = 1'b0;
    end
    if (r.bvalid && s_axi_bready) begin
      next_r.bvalid = 1'b0;
      next_r.awready = 1'b1;
      next_r.wready = 1'b1;
    end

    // Register write once both halves are in.
    if (r.aw_got && r.w_got && !r.bvalid) begin
      next_r.aw_got = 1'b0;
      next_r.w_got = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp = ssdec_pkg::RESP_OKAY;
      case (r.awaddr)
        ssdec_pkg::ADDR_CTRL: begin
          wmerged = ssdec_merge({29'h0, r.ctrl}, r.wdata, r.wstrb);
          next_r.ctrl = wmerged[2:0];
        end
        ssdec_pkg::ADDR_INSTR: begin
          if (r.state != ssdec_run) begin
            next_r.instr = ssdec_merge(r.instr, r.wdata, r.wstrb);
          end
        end
        ssdec_pkg::ADDR_RESULT: begin
          wmerged = ssdec_merge({15'h0, r.operand_end}, r.wdata, r.wstrb);
          next_r.operand_end = wmerged[16:0];
        end
        ssdec_pkg::ADDR_IRQ_STAT: begin
          if (r.wstrb[0]) begin
            next_r.irq_stat = r.irq_stat & ~r.wdata[ssdec_pkg::EV_W-1:0];
          end
        end
        ssdec_pkg::ADDR_IRQ_MASK: begin
          if (r.wstrb[0]) begin
            next_r.irq_mask = r.wdata[ssdec_pkg::EV_W-1:0];
          end
        end
        ssdec_pkg::ADDR_STATUS: begin
          next_r.bresp = ssdec_pkg::RESP_OKAY;
        end
        default: begin
          next_r.bresp = ssdec_pkg::RESP_SLVERR;
        end
      endcase
    end

    // Register read.
    if (r.rvalid && s_axi_rready) begin
      next_r.rvalid = 1'b0;
      next_r.arready = 1'b1;
    end
    if (s_axi_arvalid && r.arready) begin
      next_r.arready = 1'b0;
      next_r.rvalid = 1'b1;
      next_r.rresp = ssdec_pkg::RESP_OKAY;
      case (s_axi_araddr)
        ssdec_pkg::ADDR_CTRL: next_r.rdata = {29'h0, r.ctrl};
        ssdec_pkg::ADDR_INSTR: next_r.rdata = r.instr;
        ssdec_pkg::ADDR_RESULT: next_r.rdata = {15'h0, r.operand_end};
        ssdec_pkg::ADDR_STATUS: begin
          next_r.rdata = {r.exc, r.dec.undef_flags, r.dec.upd_flags, r.dec.op,
                          r.mgmt_active, r.dec.prot_only, r.state == ssdec_done,
                          r.state == ssdec_run, 4'h0};
        end
        ssdec_pkg::ADDR_IRQ_STAT: next_r.rdata = {29'h0, r.irq_stat};
        ssdec_pkg::ADDR_IRQ_MASK: next_r.rdata = {29'h0, r.irq_mask};
        default: begin
          next_r.rdata = 32'h0000_0000;
          next_r.rresp = ssdec_pkg::RESP_SLVERR;
        end
      endcase
    end

    // Execution sequencer: the go bit self-clears when taken.
    case (r.state)
      ssdec_idle, ssdec_done: begin
        if (r.ctrl[ssdec_pkg::CTRL_GO]) begin
          next_r.ctrl[ssdec_pkg::CTRL_GO] = 1'b0;
          next_r.dec = dec_now;
          if (dec_now.op == ssdec_pkg::ssdec_op_invalid) begin
            fault = ssdec_pkg::EXC_INVALID;
          end else if (dec_now.prot_only && !r.ctrl[ssdec_pkg::CTRL_PROT]) begin
            fault = ssdec_pkg::EXC_INVALID;
          end else if (!r.ctrl[ssdec_pkg::CTRL_PROT] &&
                       r.operand_end > ssdec_pkg::REAL_LIMIT) begin
            fault = r.instr.seg_ss[0] ? ssdec_pkg::EXC_STACK :
                    ssdec_pkg::EXC_GENERAL;
          end
          next_r.exc = fault;
          if (fault != ssdec_pkg::EXC_NONE) begin
            next_r.state = ssdec_done;
            ev[ssdec_pkg::EV_FAULT] = 1'b1;
          end else begin
            next_r.state = ssdec_run;
            // Extra cycles are charged when the operand misses the cache.
            next_r.count = r.ctrl[ssdec_pkg::CTRL_CACHE_MISS] ?
                           7'(dec_now.clocks + ssdec_pkg::MISS_PENALTY) :
                           dec_now.clocks;
            next_r.mgmt_active = dec_now.mgmt_issue;
          end
        end
      end
      ssdec_run: begin
        next_r.count = 7'(r.count - 7'h01);
        if (r.count == 7'h01) begin
          next_r.state = ssdec_done;
          ev[ssdec_pkg::EV_DONE] = 1'b1;
          if (r.mgmt_active) begin
            ev[ssdec_pkg::EV_MGMT] = 1'b1;
            next_r.mgmt_active = 1'b0;
          end
        end
      end
      default: begin
        next_r.state = ssdec_idle;
      end
    endcase

    // Events set sticky bits; a set wins over a clear in the same cycle.
    next_r.irq_stat = next_r.irq_stat | ev;
    next_r.irq = |(next_r.irq_stat & next_r.irq_mask);
  end

  // ==========================================================================
  // State register.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
      r.awready <= 1'b1;
      r.wready <= 1'b1;
      r.arready <= 1'b1;
      r.state <= ssdec_idle;
      r.dec.op <= ssdec_pkg::ssdec_op_none;
    end else begin
      r <= next_r;
    end
  end

  // Outputs straight from flip-flops.
  assign s_axi_awready = r.awready;
  assign s_axi_wready = r.wready;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp = r.bresp;
  assign s_axi_arready = r.arready;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rdata = r.rdata;
  assign s_axi_rresp = r.rresp;
  assign irq = r.irq;

endmodule : ssdec_top

// *** verification/ssdec_monitor.sv ***
// ==========================================================================
// Bus and interrupt checker for the decoder register block.
module ssdec_monitor (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Write channels.
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read channels.
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Interrupt.
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;

  logic rd_hit;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Remembers whether the accepted read address names an aligned register.
  always_ff @(posedge aclk) begin
    if (s_axi_arvalid && s_axi_arready) begin
      rd_hit <= (s_axi_araddr <= ssdec_pkg::ADDR_IRQ_MASK) && (s_axi_araddr[1:0] == 2'h0);
    end
  end

  // ==========================================================================
  // Handshake steps.
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence

  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence

  // ==========================================================================
  // Checks.
  chk_b_follows: assert property (s_wr_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  chk_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  chk_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted during response");
  chk_r_follows: assert property (s_rd_taken |=> s_axi_rvalid)
    else $error("read data late");
  chk_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  chk_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted during data");
  chk_r_code: assert property (s_axi_rvalid |->
    s_axi_rresp == (rd_hit ? ssdec_pkg::RESP_OKAY : ssdec_pkg::RESP_SLVERR))
    else $error("read response code wrong");
  chk_r_zero: assert property (s_axi_rvalid && s_axi_rresp == ssdec_pkg::RESP_SLVERR
    |-> s_axi_rdata == 32'h0) else $error("unmapped read data not zero");
  chk_irq_reset: assert property ($rose(aresetn) |-> !irq)
    else $error("interrupt high after reset");
endmodule : ssdec_monitor

bind ssdec_top ssdec_monitor i_mon (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .irq(irq)
);

// *** verification/test_store_shift_smi_decode.sv ***
// ==========================================================================
// Register-level bench for the decoder block.
module test_store_shift_smi_decode;
  timeunit 1ns;
  timeprecision 1ps;

  logic aclk, aresetn, irq;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int error_cnt = 0;
  int n_checks = 0;

  ssdec_top i_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .irq(irq)
  );

  // Free-running 250 MHz clock.
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  // ==========================================================================
  // Compares one value and counts the outcome.
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s: expected %0h, seen %0h", nm, e, g);
    end
  endtask : cmp

  // Prints the counts and the verdict, then stops.
  task automatic summarize();
    $display("checks %0d, errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : summarize

  // Write cycle: address and data offered together, each released when taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] v,
      input logic [1:0] er = ssdec_pkg::RESP_OKAY);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= v;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    cmp("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
  endtask : wr

  // Read cycle: data and response taken at the edge where rvalid is seen.
  task automatic rd(input logic [7:0] a, output logic [31:0] v,
      input logic [1:0] er = ssdec_pkg::RESP_OKAY);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    v = s_axi_rdata;
    s_axi_rready <= 1'b0;
    cmp("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
  endtask : rd

  // Runs one instruction, times it to the interrupt and checks status and events.
  task automatic run(input logic [31:0] ins, input logic [2:0] ctl, input logic [3:0] op,
      input int n, input logic [7:0] exc, input logic [11:0] fl);
    int lat;
    logic [31:0] v;
    wr(ssdec_pkg::ADDR_INSTR, ins);
    wr(ssdec_pkg::ADDR_CTRL, {29'h0, ctl | 3'h2});
    lat = 0;
    while (irq !== 1'b1 && lat < 400) begin
      @(posedge aclk);
      lat++;
    end
    rd(ssdec_pkg::ADDR_STATUS, v);
    cmp("status_exc", {24'h0, exc}, {24'h0, v[31:24]});
    cmp("status_done", 32'h1, {31'h0, v[5]});
    rd(ssdec_pkg::ADDR_IRQ_STAT, d);
    if (exc === ssdec_pkg::EXC_NONE) begin
      cmp("status_op", {28'h0, op}, {28'h0, v[11:8]});
      cmp("status_flags", {20'h0, fl}, {20'h0, v[23:12]});
      cmp("irq_events", (op === 4'hB) ? 32'h5 : 32'h1, d);
      // Go is taken the edge after the write answer; irq rises with done and is seen one edge later.
      cmp("latency", n + 1, lat);
    end else begin
      cmp("irq_fault", 32'h1, {31'h0, d[1]});
    end
    wr(ssdec_pkg::ADDR_IRQ_STAT, 32'h00000007);
    rd(ssdec_pkg::ADDR_IRQ_STAT, d);
    cmp("irq_cleared", 32'h0, d);
    cmp("irq_low", 32'h0, {31'h0, irq});
  endtask : run

  // Cuts a hung run short.
  initial begin
    repeat (30000) @(posedge aclk);
    error_cnt++;
    summarize();
  end

  // ==========================================================================
  // Main sequence.
  initial begin
    aresetn = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 8'h00;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    // Reset values and an unmapped place.
    rd(ssdec_pkg::ADDR_CTRL, d);
    cmp("ctrl_reset", 32'h0, d);
    rd(ssdec_pkg::ADDR_IRQ_MASK, d);
    cmp("mask_reset", 32'h0, d);
    rd(8'h40, d, ssdec_pkg::RESP_SLVERR);
    cmp("unmapped_data", 32'h0, d);
    wr(8'h40, 32'hFFFFFFFF, ssdec_pkg::RESP_SLVERR);
    // Masked completion sets status but keeps the output low until unmasked.
    wr(ssdec_pkg::ADDR_INSTR, 32'h0F010000);
    wr(ssdec_pkg::ADDR_CTRL, 32'h00000003);
    repeat (40) @(posedge aclk);
    cmp("irq_masked", 32'h0, {31'h0, irq});
    rd(ssdec_pkg::ADDR_IRQ_STAT, d);
    cmp("irq_stat", 32'h1, d);
    wr(ssdec_pkg::ADDR_IRQ_MASK, 32'h00000007);
    rd(ssdec_pkg::ADDR_IRQ_MASK, d);
    cmp("mask_rw", 32'h7, d);
    cmp("irq_unmasked", 32'h1, {31'h0, irq});
    wr(ssdec_pkg::ADDR_IRQ_STAT, 32'h00000007);
    // Instruction table: word, mode bits, class, clocks, exception, undef and updated flags.
    run(32'h0F000000, 3'h1, 4'h3, 1, 8'h00, 12'h000);
    run(32'h0F010000, 3'h1, 4'h1, 6, 8'h00, 12'h000);
    run(32'h0F010000, 3'h0, 4'h1, 6, 8'h00, 12'h000);
    run(32'h0F010800, 3'h0, 4'h2, 6, 8'h00, 12'h000);
    run(32'h0F000800, 3'h1, 4'h4, 3, 8'h00, 12'h000);
    run(32'h0F012000, 3'h0, 4'h5, 4, 8'h00, 12'h000);
    run(32'hAA000000, 3'h0, 4'h6, 2, 8'h00, 12'h000);
    run(32'hD1202000, 3'h1, 4'h7, 1, 8'h00, 12'h13B);
    run(32'hD3202000, 3'h1, 4'h7, 2, 8'h00, 12'h91B);
    run(32'hC1202000, 3'h1, 4'h7, 1, 8'h00, 12'h91B);
    run(32'h0FA40000, 3'h1, 4'h8, 3, 8'h00, 12'h91B);
    run(32'h0FA50000, 3'h1, 4'h8, 6, 8'h00, 12'h91B);
    run(32'hD1282800, 3'h1, 4'h9, 2, 8'h00, 12'h13B);
    run(32'hD3282800, 3'h1, 4'h9, 2, 8'h00, 12'h91B);
    run(32'hC1282800, 3'h1, 4'h9, 2, 8'h00, 12'h91B);
    run(32'h0FAC0000, 3'h1, 4'hA, 3, 8'h00, 12'h91B);
    run(32'h0FAD0000, 3'h1, 4'hA, 6, 8'h00, 12'h91B);
    run(32'h0F380000, 3'h0, 4'hB, 84, 8'h00, 12'h000);
    run(32'h0F000000, 3'h0, 4'h3, 0, 8'h06, 12'h000);
    run(32'h0F000800, 3'h0, 4'h4, 0, 8'h06, 12'h000);
    run(32'h0F003800, 3'h1, 4'hC, 0, 8'h06, 12'h000);
    run(32'h0F011000, 3'h1, 4'hC, 0, 8'h06, 12'h000);
    run(32'hD1000000, 3'h1, 4'hC, 0, 8'h06, 12'h000);
    run(32'h0F010000, 3'h5, 4'h1, 10, 8'h00, 12'h000);
    // Real-mode operand end address at and beyond the segment limit.
    wr(ssdec_pkg::ADDR_RESULT, 32'h0000FFFF);
    run(32'h0F010000, 3'h0, 4'h1, 6, 8'h00, 12'h000);
    wr(ssdec_pkg::ADDR_RESULT, 32'h00010000);
    run(32'h0F010000, 3'h0, 4'h1, 0, 8'h0D, 12'h000);
    run(32'h0F010001, 3'h0, 4'h1, 0, 8'h0C, 12'h000);
    summarize();
  end
endmodule : test_store_shift_smi_decode
